// ===== hdl/scl_loader.sv
// Serial configuration loader: header parse, frame check, daisy-chain forwarding
`timescale 1ns/100ps
`default_nettype none
module scl_loader
    import scl_pkg::*;
#(
    parameter int FRAME_BITS = scl_pkg::FRAME_BITS_DEF,
    parameter int FRAMES = scl_pkg::FRAMES_DEF
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] mode_sel,
    input wire logic program_n,
    input wire logic fast_rate_sel,
    input wire logic crc_check_sel,
    input wire logic config_clock_in,
    output logic config_clock_out,
    output logic config_clock_oe,
    input wire logic data_in,
    output logic data_out,
    output logic init_n_out,
    output logic init_n_oe,
    output logic done,
    output logic user_io_release,
    output logic low_during_config
);
    import scl_pkg::*;

    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
        logic fb;
        fb = c[CRC_W-1] ^ b;
        crc_step = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    endfunction : crc_step

    // System-domain reset release
    logic [1:0] rst_pipe;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_n = rst_pipe[1];

    // Pin inputs into the system domain
    logic [3:0] pins_s;
    scl_sync #(.W(4), .INIT(4'hF)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({mode_sel, program_n, fast_rate_sel}),
        .q(pins_s)
    );

    // Link status back into the system domain
    logic err_l;
    logic done_l;
    logic rel_l;
    logic first_l;
    logic [3:0] stat_s;
    scl_sync #(.W(4), .INIT(4'h0)) u_stat_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({err_l, done_l, rel_l, first_l}),
        .q(stat_s)
    );

    // Memory init hold, mode capture up to release
    logic [2:0] hold_cnt;
    logic [2:0] next_hold_cnt;
    logic [1:0] mode_reg;
    logic [1:0] next_mode_reg;
    logic link_run_n;
    logic next_link_run_n;
    logic master;
    logic fast_on;
    logic next_fast_on;
    logic next_config_clock_oe;
    logic next_init_n_oe;
    logic next_done;
    logic next_rel;
    logic next_ldc;

    always_comb
    begin
        next_hold_cnt = hold_cnt;
        next_mode_reg = mode_reg;
        next_fast_on = fast_on;
        // Reprogram low reopens the hold and clears memory
        if (!pins_s[1])
            next_hold_cnt = 3'h0;
        else if (hold_cnt != 3'(HOLD_CYCLES))
            next_hold_cnt = hold_cnt + 3'h1;
        next_link_run_n = (hold_cnt == 3'(HOLD_CYCLES));
        // Taken up to the edge that frees the link, so the pin synchroniser has settled
        if (!link_run_n)
        begin
            next_mode_reg = pins_s[3:2];
            next_fast_on = 1'b0;
        end
        else if (pins_s[0] && stat_s[0])
            next_fast_on = 1'b1;
        next_config_clock_oe = (mode_reg == MODE_MASTER);
        next_init_n_oe = !link_run_n || stat_s[3];
        next_done = stat_s[2] && link_run_n;
        next_rel = stat_s[1] && link_run_n;
        next_ldc = stat_s[2] && link_run_n;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_cnt <= 3'h0;
            mode_reg <= MODE_SLAVE;
            link_run_n <= 1'b0;
            fast_on <= 1'b0;
            config_clock_oe <= 1'b0;
            init_n_oe <= 1'b1;
            init_n_out <= 1'b0;
            done <= 1'b0;
            user_io_release <= 1'b0;
            low_during_config <= 1'b0;
        end
        else
        begin
            hold_cnt <= next_hold_cnt;
            mode_reg <= next_mode_reg;
            link_run_n <= next_link_run_n;
            fast_on <= next_fast_on;
            config_clock_oe <= next_config_clock_oe;
            init_n_oe <= next_init_n_oe;
            init_n_out <= 1'b0;
            done <= next_done;
            user_io_release <= next_rel;
            low_during_config <= next_ldc;
        end
    end

    // Only an exact master code selects master; anything else falls to slave
    assign master = (mode_reg == MODE_MASTER);

    // Divider runs regardless of loader state, even after an error
    scl_clkdiv u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(master),
        .fast(fast_on),
        .clk_out(config_clock_out)
    );

    // Link domain on the configuration clock pin; master clock loops back through the pin
    logic [1:0] lrst_pipe;
    logic lrst_n;
    always_ff @(posedge config_clock_in or negedge link_run_n)
    begin
        if (!link_run_n)
            lrst_pipe <= 2'h0;
        else
            lrst_pipe <= {lrst_pipe[0], 1'b1};
    end
    assign lrst_n = lrst_pipe[1];

    logic [1:0] lopt;
    scl_sync #(.W(2), .INIT(2'h0)) u_opt_sync (
        .clk(config_clock_in),
        .rst_n(lrst_n),
        .d({master, crc_check_sel}),
        .q(lopt)
    );

    scl_state_t state;
    scl_state_t next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [15:0] frame_idx;
    logic [15:0] next_frame_idx;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [LEN_W-1:0] len;
    logic [LEN_W-1:0] next_len;
    logic len_ok;
    logic next_len_ok;
    logic [LEN_W-1:0] clk_cnt;
    logic [LEN_W-1:0] next_clk_cnt;
    logic [CRC_W-1:0] crc;
    logic [CRC_W-1:0] next_crc;
    logic [LAST_CHECK_W-1:0] tail;
    logic [LAST_CHECK_W-1:0] next_tail;
    logic fwd;
    logic next_fwd;
    logic fwd_d;
    logic next_err;
    logic next_done_l;
    logic next_rel_l;
    logic next_first;
    logic last_frame;
    logic check_ok;
    logic next_dout;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt + 16'h0001;
        next_frame_idx = frame_idx;
        next_sh = {sh[6:0], data_in};
        next_len = len;
        next_len_ok = len_ok;
        next_crc = crc;
        next_tail = {tail[LAST_CHECK_W-2:0], data_in};
        next_first = first_l;
        last_frame = (frame_idx == 16'(FRAMES - 1));
        check_ok = 1'b0;
        if (lopt[0] && last_frame)
            check_ok = next_tail == crc[LAST_CHECK_W-1:0];
        else if (lopt[0])
            check_ok = next_tail[CHECK_W-1:0] == crc[CHECK_W-1:0];
        else
            check_ok = next_tail[CHECK_W-1:0] == CONST_CHECK;
        case (state)
            S_HUNT:
            begin
                if (next_sh[3:0] == PREAMBLE)
                begin
                    next_state = S_LEN;
                    next_cnt = 16'h0000;
                end
            end
            S_LEN:
            begin
                next_len = {len[LEN_W-2:0], data_in};
                if (cnt == 16'(LEN_W - 1))
                begin
                    next_state = S_FILL;
                    next_cnt = 16'h0000;
                    next_len_ok = 1'b1;
                end
            end
            S_FILL:
            begin
                if (cnt == 16'(FILL_BITS - 1))
                    next_state = S_START;
            end
            S_START:
            begin
                next_cnt = 16'h0000;
                next_first = 1'b1;
                next_state = (data_in == START_BIT) ? S_DATA : S_ERR;
            end
            S_DATA:
            begin
                // Last seven data bits of the final frame join the wide check
                if (!(lopt[0] && last_frame && cnt >= 16'(FRAME_BITS - LAST_TAIL_BITS)))
                    next_crc = crc_step(crc, data_in);
                if (cnt == 16'(FRAME_BITS - 1))
                begin
                    next_state = S_CHECK;
                    next_cnt = 16'h0000;
                end
            end
            S_CHECK:
            begin
                if (cnt == 16'(CHECK_W - 1))
                begin
                    next_cnt = 16'h0000;
                    if (!check_ok)
                        next_state = S_ERR;
                    else if (last_frame)
                        next_state = S_POST;
                    else
                    begin
                        next_state = S_START;
                        next_frame_idx = frame_idx + 16'h0001;
                    end
                end
            end
            S_POST:
            begin
                if (cnt == 16'(POST_W - 1))
                    next_state = (next_sh == POSTAMBLE) ? S_PASS : S_ERR;
            end
            S_PASS:
            begin
                next_cnt = cnt;
            end
            S_ERR:
            begin
                next_cnt = cnt;
            end
            default:
            begin
                next_state = S_ERR;
            end
        endcase
        // Header and overflow pass through, own frames are masked high
        case (state)
            S_HUNT, S_LEN, S_PASS:
                next_fwd = data_in;
            default:
                next_fwd = 1'b1;
        endcase
        // Saturating count so a stray clock tail cannot wrap onto the length
        next_clk_cnt = (clk_cnt == {LEN_W{1'b1}}) ? clk_cnt : clk_cnt + 24'h000001;
        next_err = (next_state == S_ERR);
        next_done_l = done_l || (len_ok && !next_err && clk_cnt == len);
        next_rel_l = rel_l || (len_ok && !next_err && clk_cnt == len + 24'(RELEASE_DELAY));
    end

    always_ff @(posedge config_clock_in or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            state <= S_HUNT;
            cnt <= 16'h0000;
            frame_idx <= 16'h0000;
            sh <= 8'hFF;
            len <= '0;
            len_ok <= 1'b0;
            clk_cnt <= '0;
            crc <= CRC_INIT;
            tail <= '0;
            fwd <= 1'b1;
            fwd_d <= 1'b1;
            err_l <= 1'b0;
            done_l <= 1'b0;
            rel_l <= 1'b0;
            first_l <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            frame_idx <= next_frame_idx;
            sh <= next_sh;
            len <= next_len;
            len_ok <= next_len_ok;
            clk_cnt <= next_clk_cnt;
            crc <= next_crc;
            tail <= next_tail;
            fwd <= next_fwd;
            fwd_d <= fwd;
            err_l <= next_err;
            done_l <= next_done_l;
            rel_l <= next_rel_l;
            first_l <= next_first;
        end
    end

    // Falling-edge output stage; master takes one more rising stage
    always_comb
    begin
        next_dout = lopt[1] ? fwd_d : fwd;
    end

    always_ff @(negedge config_clock_in or negedge lrst_n)
    begin
        if (!lrst_n)
            data_out <= 1'b1;
        else
            data_out <= next_dout;
    end
endmodule : scl_loader
`default_nettype wire

// ===== hdl/scl_pkg.sv
// Shared constants and types of the serial configuration loader
`default_nettype none
package scl_pkg;
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int SLOW_FREQ_KHZ = 1000;
    localparam int FAST_FREQ_KHZ = 8000;
    localparam int SLOW_HALF_CYCLES = CLK_FREQ_KHZ / (2 * SLOW_FREQ_KHZ);
    localparam int FAST_HALF_CYCLES = CLK_FREQ_KHZ / (2 * FAST_FREQ_KHZ);
    localparam int HOLD_CYCLES = 4;
    localparam int LEN_W = 24;
    localparam int FILL_BITS = 4;
    localparam int CHECK_W = 4;
    localparam int LAST_CHECK_W = 11;
    localparam int LAST_TAIL_BITS = 7;
    localparam int POST_W = 8;
    localparam int RELEASE_DELAY = 2;
    localparam int CRC_W = 16;
    localparam logic [3:0] PREAMBLE = 4'h2;
    localparam logic START_BIT = 1'b0;
    localparam logic [3:0] CONST_CHECK = 4'h6;
    localparam logic [7:0] POSTAMBLE = 8'h7F;
    localparam logic [CRC_W-1:0] CRC_POLY = 16'h8005;
    localparam logic [CRC_W-1:0] CRC_INIT = 16'h0000;
    localparam logic [1:0] MODE_MASTER = 2'h2;
    localparam logic [1:0] MODE_SLAVE = 2'h3;
    localparam int FRAME_BITS_DEF = 64;
    localparam int FRAMES_DEF = 8;

    typedef enum {
        S_HUNT,
        S_LEN,
        S_FILL,
        S_START,
        S_DATA,
        S_CHECK,
        S_POST,
        S_PASS,
        S_ERR
    } scl_state_t;
endpackage : scl_pkg
`default_nettype wire

// ===== hdl/scl_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module scl_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_q = (s2 == s3) ? s3 : q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            q <= INIT;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end
endmodule : scl_sync
`default_nettype wire

// ===== hdl/scl_clkdiv.sv
// Configuration clock divider for master mode
`timescale 1ns/100ps
`default_nettype none
module scl_clkdiv
    import scl_pkg::*;
#(
    parameter int SLOW_HALF = scl_pkg::SLOW_HALF_CYCLES,
    parameter int FAST_HALF = scl_pkg::FAST_HALF_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic fast,
    output logic clk_out
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic next_clk_out;
    logic [7:0] half;

    // 1 MHz slow and 8.33 MHz fast stay inside both bands
    always_comb
    begin
        half = fast ? 8'(FAST_HALF) : 8'(SLOW_HALF);
        next_cnt = cnt;
        next_clk_out = clk_out;
        if (!run)
        begin
            next_cnt = 8'h00;
            next_clk_out = 1'b0;
        end
        else if (cnt >= half - 8'h01)
        begin
            next_cnt = 8'h00;
            next_clk_out = ~clk_out;
        end
        else
        begin
            next_cnt = cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt <= 8'h00;
            clk_out <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            clk_out <= next_clk_out;
        end
    end
endmodule : scl_clkdiv
`default_nettype wire

// ===== sim/scl_loader_props.sv
// Port-level checks for the serial configuration loader
`timescale 1ns/100ps
`default_nettype none
module scl_loader_props
    import scl_pkg::*;
#(
    parameter int FRAME_BITS = 64,
    parameter int FRAMES = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [1:0] mode_sel,
    input wire logic program_n,
    input wire logic fast_rate_sel,
    input wire logic crc_check_sel,
    input wire logic config_clock_in,
    input wire logic config_clock_out,
    input wire logic config_clock_oe,
    input wire logic data_in,
    input wire logic data_out,
    input wire logic init_n_out,
    input wire logic init_n_oe,
    input wire logic done,
    input wire logic user_io_release,
    input wire logic low_during_config
);
    logic [7:0] hcnt;
    logic seen;
    logic prev;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_slave_mode;
        (mode_sel != MODE_MASTER) [*8];
    endsequence
    sequence s_quiet;
        program_n [*8];
    endsequence
    // Cycles since the master clock last toggled; cleared while the pin is not driven
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hcnt <= 8'h00;
            seen <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            prev <= config_clock_out;
            if (!config_clock_oe || !program_n)
            begin
                hcnt <= 8'h00;
                seen <= 1'b0;
            end
            else if (prev != config_clock_out)
            begin
                hcnt <= 8'h00;
                seen <= 1'b1;
            end
            else if (hcnt != 8'hFF)
                hcnt <= hcnt + 8'h01;
        end
    end
    AST_INIT_OPEN_DRAIN: assert property (init_n_out == 1'b0)
        else $error("init line driven high");
    AST_NO_DONE_ON_ERR: assert property (s_quiet |-> !(done && init_n_oe))
        else $error("done high while init pulled low");
    AST_RELEASE_AFTER_DONE: assert property (s_quiet ##0 user_io_release |-> done)
        else $error("user io released without done");
    AST_LDC_FOLLOWS_DONE: assert property ($rose(done) |-> ##[0:8] low_during_config)
        else $error("low during config not raised after done");
    AST_DONE_STANDS: assert property (s_quiet ##0 done |=> done)
        else $error("done dropped without restart");
    AST_SLAVE_NO_DRIVE: assert property (s_slave_mode |-> !config_clock_oe && !config_clock_out)
        else $error("clock driven in slave mode");
    AST_MCLK_MAX_HALF: assert property (seen |-> hcnt < SLOW_HALF_CYCLES)
        else $error("master clock half period too long");
    AST_MCLK_MIN_HALF: assert property (seen && prev != config_clock_out |-> hcnt >= FAST_HALF_CYCLES - 1)
        else $error("master clock half period too short");
    AST_OUT_ON_FALL: assert property ($changed(data_out) && !init_n_oe && $past(!init_n_oe)
        |-> !config_clock_in && ($past(config_clock_in) || $past(config_clock_in, 2)))
        else $error("data out changed off a falling clock");
endmodule : scl_loader_props
bind scl_loader scl_loader_props #(.FRAME_BITS(FRAME_BITS), .FRAMES(FRAMES)) u_props (.clk, .rstn, .mode_sel,
    .program_n, .fast_rate_sel, .crc_check_sel, .config_clock_in, .config_clock_out, .config_clock_oe, .data_in,
    .data_out, .init_n_out, .init_n_oe, .done, .user_io_release, .low_during_config);
`default_nettype wire

// ===== sim/scl_src_model.sv
// Serial source model: one bit presented after each rising link clock
`timescale 1ns/100ps
`default_nettype none
module scl_src_model (
    input wire logic link_clk,
    output logic bit_out
);
    // Item: bit0 data, bit1 held high downstream, bit2 unchecked
    int q[$];
    int cur;
    int it;
    initial
    begin
        bit_out = 1'b1;
        cur = 4;
    end
    always @(posedge link_clk)
    begin
        if (q.size() > 0)
        begin
            it = q.pop_front();
            cur <= it;
            bit_out <= it[0];
        end
        else
        begin
            cur <= 4;
            bit_out <= ~bit_out; // Ran dry: no stable level to lean on
        end
    end
endmodule : scl_src_model
`default_nettype wire

// ===== sim/tb.sv
// Self-checking bench for the serial configuration loader
`timescale 1ns/100ps
`default_nettype none
module tb;
    import scl_pkg::*;
    localparam int FB = 8;
    localparam int NF = 2;
    localparam int LEN = 40 + NF * (FB + 5) + 32;
    logic clk, rstn, program_n, fast_rate_sel, crc_check_sel, slave_clk, data_in;
    logic [1:0] mode_sel;
    logic config_clock_out, config_clock_oe, data_out, init_n_out, init_n_oe, done, user_io_release;
    logic low_during_config;
    wire logic cfg_clk;
    int errors, tests_run, lag, crc, fq[$];
    bit chk_fwd;
    real t0;
    assign cfg_clk = config_clock_oe ? config_clock_out : slave_clk;
    scl_loader #(.FRAME_BITS(FB), .FRAMES(NF)) uut (.clk, .rstn, .mode_sel, .program_n, .fast_rate_sel,
        .crc_check_sel, .config_clock_in(cfg_clk), .config_clock_out, .config_clock_oe, .data_in, .data_out,
        .init_n_out, .init_n_oe, .done, .user_io_release, .low_during_config);
    scl_src_model u_src (.link_clk(cfg_clk), .bit_out(data_in));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk1(string n, logic e, logic s);
        tests_run++;
        if (s !== e)
        begin
            errors++;
            $display("[ERR] %s expected %b seen %b", n, e, s);
        end
    endtask : chk1
    task automatic chk_rng(string n, real v, real lo, real hi);
        tests_run++;
        if (v < lo || v > hi)
        begin
            errors++;
            $display("[ERR] %s expected %0.1f..%0.1f seen %0.1f", n, lo, hi, v);
        end
    endtask : chk_rng
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // Slave link clock runs only while the bench steps it, ending 12 edges after the last queued bit
    task automatic edges(int n);
        repeat (n)
            if (mode_sel == MODE_MASTER)
                @(posedge cfg_clk);
            else
            begin
                #62.5 slave_clk = 1'b1;
                #62.5 slave_clk = 1'b0;
            end
    endtask : edges
    task automatic put(int v, int w, int cls);
        for (int i = w - 1; i >= 0; i--)
            u_src.q.push_back(((v >> i) & 1) | cls);
    endtask : put
    task automatic per_chk(bit f);
        @(posedge cfg_clk) t0 = $realtime;
        @(posedge cfg_clk) chk_rng("clock period", $realtime - t0, f ? 100 : 800, f ? 250 : 2000);
    endtask : per_chk
    task automatic run(logic [1:0] m, logic c, logic f, int bad, bit prog);
        int d, n;
        fq.delete();
        u_src.q.delete();
        chk_fwd = 1'b0;
        crc = 0;
        lag = (m == MODE_MASTER) ? 1 : 0;
        @(posedge clk);
        if (prog)
            program_n <= 1'b0;
        else
            rstn <= 1'b0;
        mode_sel <= m;
        crc_check_sel <= c;
        fast_rate_sel <= f;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        program_n <= 1'b1;
        put(32'hFFF, 12, 0);
        n = 0;
        while (init_n_oe !== 1'b0 && n < 400)
        begin
            edges(1);
            n++;
        end
        chk1("init released", 1'b0, init_n_oe);
        if (m == MODE_MASTER)
            per_chk(1'b0);
        chk_fwd = (bad == 0);
        put(8'hFF, 8, 0);
        put(4'h2, 4, 0);
        put(LEN, 24, 0);
        put(4'hF, 4, 2);
        for (int fr = 0; fr < NF; fr++)
        begin
            put(0, 1, 2);
            for (int i = 0; i < FB; i++)
            begin
                if (c && fr == NF - 1 && i >= FB - 7)
                    d = (crc >> (10 - i + FB - 7)) & 1;
                else
                begin
                    d = $urandom_range(1);
                    crc = ((crc << 1) ^ ((((crc >> 15) ^ d) & 1) ? int'(CRC_POLY) : 0)) & 32'hFFFF;
                end
                put(d, 1, 2);
            end
            put((c ? crc & 15 : int'(CONST_CHECK)) ^ ((bad == 1 && fr == NF - 1) ? 1 : 0), 4, 2);
        end
        put(bad == 2 ? 8'h7E : 8'h7F, 8, 2);
        put($urandom, 16, 0);
        put(16'hFFFF, 16, 0);
        while (u_src.q.size() > 28)
            edges(1);
        if (bad == 0)
            chk1("done early", 1'b0, done);
        if (m == MODE_MASTER && bad == 0)
            per_chk(f);
        edges(40);
        chk_fwd = 1'b0;
        repeat (10) @(posedge clk);
        chk1("done", bad == 0, done);
        chk1("user io", bad == 0, user_io_release);
        chk1("ldc", bad == 0, low_during_config);
        chk1("init low", bad != 0, init_n_oe);
        chk1("init out", 1'b0, init_n_out);
        if (m == MODE_MASTER && bad != 0)
            per_chk(1'b0);
        chk1("clock drive", m == MODE_MASTER, config_clock_oe);
        $display("test mode %b crc %b fast %b fault %0d ended", m, c, f, bad);
    endtask : run
    always @(posedge cfg_clk)
        fq.push_back(u_src.cur);
    always @(negedge cfg_clk)
    begin
        #1;
        if (chk_fwd && fq.size() > lag && !fq[$ - lag][2])
            chk1("data out", fq[$ - lag][1] | fq[$ - lag][0], data_out);
    end
    initial
    begin
        #600000;
        errors++;
        $display("[ERR] watchdog expected finish seen timeout");
        finish_test();
    end
    initial
    begin
        rstn = 1'b0;
        program_n = 1'b1;
        fast_rate_sel = 1'b0;
        crc_check_sel = 1'b0;
        slave_clk = 1'b0;
        mode_sel = 2'h3;
        errors = 0;
        tests_run = 0;
        chk_fwd = 1'b0;
        void'($urandom(51));
        run(2'h3, 1'b0, 1'b0, 0, 1'b0);
        run(2'h1, 1'b1, 1'b0, 1, 1'b0);
        run(2'h1, 1'b1, 1'b0, 0, 1'b1);
        run(MODE_MASTER, 1'b0, 1'b1, 0, 1'b0);
        run(MODE_MASTER, 1'b0, 1'b0, 2, 1'b0);
        finish_test();
    end
endmodule : tb
`default_nettype wire
